// ---- rtl/wwdt_acc_if.sv ----
// carries memory-size settings and cpu access addresses from the watchdog
// top to its access checker, and the two verdicts back.
// assumes both ends sit on the same core clock.
`timescale 1ns/10ps
interface wwdt_acc_if;
   logic [7:0]  internal_memory_size_select;
   logic [7:0]  expansion_ram_size_select;
   logic        fetch_valid;
   logic [15:0] fetch_addr;
   logic        data_valid;
   logic [15:0] data_addr;
   logic        fetch_bad;
   logic        data_bad;

   modport mon (output internal_memory_size_select, output expansion_ram_size_select, output fetch_valid, output fetch_addr,
                output data_valid, output data_addr, input fetch_bad, input data_bad);
   modport chk (input internal_memory_size_select, input expansion_ram_size_select, input fetch_valid, input fetch_addr,
                input data_valid, input data_addr, output fetch_bad, output data_bad);
endinterface

// ---- rtl/wwdt_access_chk.sv ----
// combinational check of cpu fetch and data addresses against the memory
// configured by the size settings; arming is done by the caller.
// assumes addresses are 16 bits and sizes come from registers.
`timescale 1ns/10ps
module wwdt_access_chk
   import wwdt_pkg::*;
(
   wwdt_acc_if.chk acc
);
   import wwdt_pkg::*;

   // rom ends at (ims[3:0]+1) * 4 KB - 1
   function automatic logic [15:0] rom_end(input logic [7:0] internal_memory_size_select);
      rom_end = 16'({internal_memory_size_select[3:0], 12'hFFF});
   endfunction

   // high-speed ram sits below the sfr area, (ims[7:6]+1) * 256 bytes
   function automatic logic [15:0] hsram_lo(input logic [7:0] internal_memory_size_select);
      hsram_lo = 16'(HSRAM_TOP - {6'h00, internal_memory_size_select[7:6], 8'hFF});
   endfunction

   // expansion ram: (12 - ixs[3:0]) / 2 KB up from its base, zero if none
   function automatic logic [15:0] xram_end(input logic [7:0] expansion_ram_size_select);
      logic [4:0] half_kb;
      half_kb  = 5'(5'd12 - {1'b0, expansion_ram_size_select[3:0]});
      xram_end = 16'(XRAM_BASE + {half_kb, 9'h000} - 16'h0001);
   endfunction

   function automatic logic in_cfg(input logic [15:0] a, input logic [7:0] internal_memory_size_select,
                                   input logic [7:0] expansion_ram_size_select);
      in_cfg = (a <= rom_end(internal_memory_size_select))
             || (a >= hsram_lo(internal_memory_size_select) && a <= HSRAM_TOP)
             || (expansion_ram_size_select[3:0] < 4'hC && a >= XRAM_BASE && a <= xram_end(expansion_ram_size_select));
   endfunction

   // fetches must hit configured memory; data gets two exempt ranges
   always_comb
   begin
      acc.fetch_bad = acc.fetch_valid && !in_cfg(acc.fetch_addr, acc.internal_memory_size_select, acc.expansion_ram_size_select);
      acc.data_bad  = acc.data_valid && !in_cfg(acc.data_addr, acc.internal_memory_size_select, acc.expansion_ram_size_select)
                    && !(acc.data_addr >= EXEMPT_A_LO && acc.data_addr <= EXEMPT_A_HI)
                    && !(acc.data_addr >= EXEMPT_B_LO && acc.data_addr <= EXEMPT_B_HI);
   end
endmodule

// ---- rtl/wwdt_pkg.sv ----
// constants shared by the windowed watchdog: register map, option byte
// layout, key code, timing counts and the two exempt data-access windows.
// assumes a 200 MHz core clock and a 32-bit AXI4-Lite register bus.
package wwdt_pkg;

   // ----------------------------------------------------------------
   // register map (byte addresses, one aligned word each)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CLEAR     = 8'h00;  // key write, byte access
   localparam logic [7:0] OFS_CLEAR_BIT = 8'h04;  // single-bit manipulation
   localparam logic [7:0] OFS_IMS       = 8'h08;  // internal memory size
   localparam logic [7:0] OFS_IXS       = 8'h0C;  // expansion ram size
   localparam logic [7:0] OFS_STATUS    = 8'h10;  // sticky events, read only
   localparam logic [7:0] OFS_INT_EN    = 8'h14;  // interrupt enable
   localparam logic [7:0] OFS_INT_CLR   = 8'h18;  // write one to clear
   localparam logic [7:0] OFS_COUNT     = 8'h1C;  // counter and state

   localparam logic [7:0] IMS_RESET = 8'hCF;
   localparam logic [7:0] IXS_RESET = 8'h0C;

   // ----------------------------------------------------------------
   // option byte fields and key
   // ----------------------------------------------------------------
   localparam int         OPT_RUN_BIT  = 4;
   localparam int         OPT_OVF_LSB  = 1;
   localparam int         OPT_WIN_LSB  = 5;
   localparam logic [7:0] CLEAR_KEY    = 8'hAC;

   // status bit positions
   localparam int ST_OVERFLOW  = 0;
   localparam int ST_WINDOW    = 1;
   localparam int ST_BAD_KEY   = 2;
   localparam int ST_BIT_OP    = 3;
   localparam int ST_FETCH     = 4;
   localparam int ST_DATA      = 5;
   localparam int ST_WIDTH     = 6;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CORE_CLK_KHZ   = 200000;
   localparam int LOW_CLK_KHZ    = 240;   // low_speed_ring_clock rate
   localparam int LOW_TICK_CYC   = CORE_CLK_KHZ / LOW_CLK_KHZ;
   localparam int OVF_BASE_SHIFT = 9;     // select 0 gives 2^9 ticks
   localparam int RST_PULSE_CYC  = 4;

   // ----------------------------------------------------------------
   // memory map limits
   // ----------------------------------------------------------------
   localparam logic [15:0] EXEMPT_A_LO = 16'hFB00;
   localparam logic [15:0] EXEMPT_A_HI = 16'hFFCF;
   localparam logic [15:0] EXEMPT_B_LO = 16'hFFE0;
   localparam logic [15:0] EXEMPT_B_HI = 16'hFFFF;
   localparam logic [15:0] HSRAM_TOP   = 16'hFEFF;
   localparam logic [15:0] XRAM_BASE   = 16'hE000;

   typedef enum logic [1:0]
   {
      WWDT_RESET_T_IDLE  = 2'b00,
      WWDT_RESET_T_PULSE = 2'b01
   } wwdt_rst_state_t;

endpackage

// ---- rtl/wwdt_top.sv ----
// windowed watchdog timer with an AXI4-Lite register slave, option byte
// input, cpu access monitor, internal reset request and interrupt.
// assumes option byte, cpu address strobes and bus are synchronous to core_clk.
`timescale 1ns/10ps
module wwdt_top
   import wwdt_pkg::*;
(
   input  wire  logic        core_clk,
   input  wire  logic        rst,
   input  wire  logic [7:0]  option_byte,
   input  wire  logic        fetch_valid,
   input  wire  logic [15:0] fetch_addr,
   input  wire  logic        data_valid,
   input  wire  logic [15:0] data_addr,
   input  wire  logic [7:0]  s_axi_awaddr,
   input  wire  logic        s_axi_awvalid,
   output logic              s_axi_awready,
   input  wire  logic [31:0] s_axi_wdata,
   input  wire  logic [3:0]  s_axi_wstrb,
   input  wire  logic        s_axi_wvalid,
   output logic              s_axi_wready,
   output logic [1:0]        s_axi_bresp,
   output logic              s_axi_bvalid,
   input  wire  logic        s_axi_bready,
   input  wire  logic [7:0]  s_axi_araddr,
   input  wire  logic        s_axi_arvalid,
   output logic              s_axi_arready,
   output logic [31:0]       s_axi_rdata,
   output logic [1:0]        s_axi_rresp,
   output logic              s_axi_rvalid,
   input  wire  logic        s_axi_rready,
   output logic              wdt_reset_req,
   output logic              irq
);
   import wwdt_pkg::*;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // ticks until overflow for a given select
   function automatic logic [16:0] ovf_limit(input logic [2:0] sel);
      ovf_limit = 17'(17'h00001 << (OVF_BASE_SHIFT + int'(sel)));
   endfunction

   // ticks of closed window: 25/50/75/100 % of the period open
   function automatic logic [16:0] closed_len(input logic [2:0] osel, input logic [1:0] wsel);
      closed_len = 17'((ovf_limit(osel) >> 2) * (17'd3 - {15'h0000, wsel}));
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a[1:0] == 2'b00) && (a <= OFS_COUNT);
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic                  loaded_ff;
   logic [7:0]            opt_ff;
   logic [7:0]            ims_ff;
   logic [7:0]            ixs_ff;
   logic [ST_WIDTH-1:0]   status_ff;
   logic [ST_WIDTH-1:0]   int_en_ff;
   logic [9:0]            presc_ff;
   logic [15:0]           cnt_ff;
   logic                  first_done_ff;
   logic                  chk_fetch_ff;
   logic                  chk_data_ff;
   wwdt_rst_state_t       rst_state_ff;
   logic [2:0]            rst_cnt_ff;
   logic                  aw_held_ff;
   logic                  w_held_ff;
   logic [7:0]            awaddr_ff;
   logic [31:0]           wdata_ff;
   logic [3:0]            wstrb_ff;

   logic                  run;
   logic                  tick;
   logic                  last_count;
   logic                  win_open;
   logic                  wr_fire;
   logic                  clr_wr;
   logic                  bit_wr;
   logic [ST_WIDTH-1:0]   events;
   logic                  any_cause;
   logic                  wdt_init;
   logic [2:0]            ovf_sel;
   logic [1:0]            win_sel;
   logic [16:0]           nxt_cnt;

   wwdt_acc_if acc ();

   // option byte is non-volatile: caught once just after reset release
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         loaded_ff <= 1'b0;
         opt_ff    <= 8'h00;
      end
      else if (!loaded_ff)
      begin
         loaded_ff <= 1'b1;
         opt_ff    <= option_byte;
      end
   end

   assign run     = loaded_ff && opt_ff[OPT_RUN_BIT];
   assign ovf_sel = opt_ff[OPT_OVF_LSB +: 3];
   assign win_sel = opt_ff[OPT_WIN_LSB +: 2];
   assign wdt_init = (rst_state_ff == WWDT_RESET_T_PULSE);

   // ----------------------------------------------------------------
   // slow tick and counter
   // ----------------------------------------------------------------
   // prescaler keeps running across key clears; that costs up to one tick
   // of period error but avoids a glitchy restart of the slow clock
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         presc_ff <= 10'h000;
      else if (!run || wdt_init || tick)
         presc_ff <= 10'h000;
      else
         presc_ff <= 10'(presc_ff + 10'h001);
   end

   assign tick       = run && (presc_ff == 10'(LOW_TICK_CYC - 1));
   assign nxt_cnt    = {1'b0, cnt_ff} + 17'h00001;
   assign last_count = (nxt_cnt == ovf_limit(ovf_sel));
   assign win_open   = ({1'b0, cnt_ff} >= closed_len(ovf_sel, win_sel));

   // counter starts by itself once enabled; key clear beats the tick
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         cnt_ff <= 16'h0000;
      else if (wdt_init)
         cnt_ff <= 16'h0000;
      else if (clr_wr && run && wr_data[7:0] == CLEAR_KEY)
         cnt_ff <= 16'h0000;
      else if (tick && !last_count)
         cnt_ff <= nxt_cnt[15:0];
   end

   // first clear after reset is exempt from the window check
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         first_done_ff <= 1'b0;
      else if (wdt_init)
         first_done_ff <= 1'b0;
      else if (clr_wr && run)
         first_done_ff <= 1'b1;
   end

   // ----------------------------------------------------------------
   // reset causes
   // ----------------------------------------------------------------
   assign acc.internal_memory_size_select         = ims_ff;
   assign acc.expansion_ram_size_select         = ixs_ff;
   assign acc.fetch_valid = fetch_valid;
   assign acc.fetch_addr  = fetch_addr;
   assign acc.data_valid  = data_valid;
   assign acc.data_addr   = data_addr;

   wwdt_access_chk u_chk
   (
      .acc (acc.chk)
   );

   // registered to keep the long address compare off the reset path
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         chk_fetch_ff <= 1'b0;
         chk_data_ff  <= 1'b0;
      end
      else
      begin
         chk_fetch_ff <= acc.fetch_bad;
         chk_data_ff  <= acc.data_bad;
      end
   end

   // key clear on the last count wins over overflow
   always_comb
   begin
      events              = '0;
      events[ST_OVERFLOW] = tick && last_count && !(clr_wr && wr_data[7:0] == CLEAR_KEY);
      events[ST_WINDOW]   = clr_wr && first_done_ff && !win_open;
      events[ST_BAD_KEY]  = clr_wr && wr_data[7:0] != CLEAR_KEY;
      events[ST_BIT_OP]   = bit_wr;
      events[ST_FETCH]    = chk_fetch_ff;
      events[ST_DATA]     = chk_data_ff;
      if (!run || wdt_init)
         events = '0;
   end

   assign any_cause = |events;

   // reset request is held for a fixed number of cycles
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         rst_state_ff  <= WWDT_RESET_T_IDLE;
         rst_cnt_ff    <= 3'h0;
         wdt_reset_req <= 1'b0;
      end
      else
      begin
         case (rst_state_ff)
            WWDT_RESET_T_IDLE:
            begin
               if (any_cause)
               begin
                  rst_state_ff  <= WWDT_RESET_T_PULSE;
                  rst_cnt_ff    <= 3'(RST_PULSE_CYC - 1);
                  wdt_reset_req <= 1'b1;
               end
            end
            WWDT_RESET_T_PULSE:
            begin
               if (rst_cnt_ff == 3'h0)
               begin
                  rst_state_ff  <= WWDT_RESET_T_IDLE;
                  wdt_reset_req <= 1'b0;
               end
               else
                  rst_cnt_ff <= 3'(rst_cnt_ff - 3'h1);
            end
            default:
            begin
               rst_state_ff  <= WWDT_RESET_T_IDLE;
               wdt_reset_req <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------------------------------
   assign wr_fire = (aw_held_ff || (s_axi_awvalid && s_axi_awready))
                 && (w_held_ff || (s_axi_wvalid && s_axi_wready)) && !s_axi_bvalid;

   logic [7:0]  wr_addr;
   logic [31:0] wr_data;
   logic [3:0]  wr_strb;
   assign wr_addr = aw_held_ff ? awaddr_ff : s_axi_awaddr;
   assign wr_data = w_held_ff ? wdata_ff : s_axi_wdata;
   assign wr_strb = w_held_ff ? wstrb_ff : s_axi_wstrb;
   // clear register takes a byte write on lane 0
   assign clr_wr = wr_fire && wr_addr == OFS_CLEAR && wr_strb[0];
   assign bit_wr = wr_fire && wr_addr == OFS_CLEAR_BIT && wr_strb[0];

   // address and data taken in either order, held until the response
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         aw_held_ff    <= 1'b0;
         w_held_ff     <= 1'b0;
         awaddr_ff     <= 8'h00;
         wdata_ff      <= 32'h00000000;
         wstrb_ff      <= 4'h0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end
      else if (wr_fire)
      begin
         aw_held_ff    <= 1'b0;
         w_held_ff     <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b1;
         s_axi_bresp   <= mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_ff    <= 1'b1;
            awaddr_ff     <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_ff    <= 1'b1;
            wdata_ff     <= s_axi_wdata;
            wstrb_ff     <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         ims_ff    <= IMS_RESET;
         ixs_ff    <= IXS_RESET;
         int_en_ff <= '0;
      end
      else if (wr_fire && wr_strb[0])
      begin
         if (wr_addr == OFS_IMS)
            ims_ff <= wr_data[7:0];
         if (wr_addr == OFS_IXS)
            ixs_ff <= wr_data[7:0];
         if (wr_addr == OFS_INT_EN)
            int_en_ff <= wr_data[ST_WIDTH-1:0];
      end
   end

   // sticky status: a new event wins over a clear in the same cycle
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         status_ff <= '0;
      else if (wr_fire && wr_strb[0] && wr_addr == OFS_INT_CLR)
         status_ff <= (status_ff & ~wr_data[ST_WIDTH-1:0]) | events;
      else
         status_ff <= status_ff | events;
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         irq <= 1'b0;
      else
         irq <= |(status_ff & int_en_ff);
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------------------------------
   logic [31:0] rd_val;
   always_comb
   begin
      rd_val = 32'h00000000;
      case (s_axi_araddr)
         OFS_IMS:    rd_val[7:0] = ims_ff;
         OFS_IXS:    rd_val[7:0] = ixs_ff;
         OFS_STATUS: rd_val[ST_WIDTH-1:0] = status_ff;
         OFS_INT_EN: rd_val[ST_WIDTH-1:0] = int_en_ff;
         OFS_COUNT:  rd_val = {12'h000, run, first_done_ff, win_open, wdt_init, cnt_ff};
         default:    rd_val = 32'h00000000;
      endcase
   end

   // one read at a time; arready drops while the answer waits
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_val;
         s_axi_rresp   <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
endmodule

// ---- test/wwdt_properties.sv ----
// checker on the watchdog top ports: bus answers, reset pulse, events.
// assumes option_byte moves only while rst is high.
`timescale 1ns/10ps
module wwdt_properties
   import wwdt_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic [7:0]  option_byte,
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        wdt_reset_req
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // armed lane-0 write; events are muted while a pulse runs, so skip those
   logic wr_hit;
   assign wr_hit = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                   && s_axi_wstrb[0] && option_byte[OPT_RUN_BIT] && !wdt_reset_req;

   chk_pulse_len: assert property ($rose(wdt_reset_req) |-> wdt_reset_req[*4] ##1 !wdt_reset_req)
      else $error("reset request pulse length wrong");
   chk_bit_op: assert property (wr_hit && s_axi_awaddr == OFS_CLEAR_BIT |-> ##[1:4] wdt_reset_req)
      else $error("bit write gave no reset request");
   chk_bad_key: assert property (wr_hit && s_axi_awaddr == OFS_CLEAR
      && s_axi_wdata[7:0] != CLEAR_KEY |-> ##[1:4] wdt_reset_req)
      else $error("wrong key gave no reset request");
   chk_run_off: assert property (!option_byte[OPT_RUN_BIT] |-> !wdt_reset_req)
      else $error("reset request while disabled");
   chk_b_after: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> s_axi_bvalid)
      else $error("write response late");
   chk_r_after: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
   chk_rd_slverr: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h1C
      |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   chk_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");

   cov_pulse: cover property ($rose(wdt_reset_req));
   cov_bit_op: cover property (wr_hit && s_axi_awaddr == OFS_CLEAR_BIT);
   cov_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule

// ---- test/wwdt_top_tb.sv ----
// self-checking bench for the watchdog top, driving AXI4-Lite and cpu strobes.
// assumes the default register map and status layout of the package.
`timescale 1ns/10ps
module wwdt_top_tb;
   import wwdt_pkg::*;
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  option_byte = 8'h10;
   logic        fetch_valid = 1'b0, data_valid = 1'b0;
   logic [15:0] fetch_addr = 16'h0, data_addr = 16'h0;
   logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        wdt_reset_req, irq;
   int          err_total = 0, compares = 0;

   always #2.5 core_clk = ~core_clk;
   wwdt_top i_wwdt_top (.*);

   task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected %s exp %h got %h", nm, exp, got);
      end
   endtask
   // both channels offered together; the slave drops both readies on accept
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do @(posedge core_clk); while (!(s_axi_awready && s_axi_wready));
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      do @(posedge core_clk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      cmp("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp,
                     input logic [1:0] er, input string nm);
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge core_clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge core_clk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      cmp(nm, exp, s_axi_rdata & m);
      cmp("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
   endtask
   // 20 cycles covers event latency plus the whole pulse
   task automatic req(input logic exp);
      logic seen;
      seen = 1'b0;
      repeat (20)
      begin
         @(posedge core_clk);
         seen = seen | wdt_reset_req;
      end
      cmp("reset_req", {31'h0, exp}, {31'h0, seen});
   endtask
   // one event: pulse, sticky bit, irq up, then cleared and irq down
   task automatic ev(input int b);
      req(1'b1);
      rd(OFS_STATUS, 32'hFF, 32'h1 << b, 2'b00, "status");
      cmp("irq", 32'h1, {31'h0, irq});
      wr(OFS_INT_CLR, 32'h1 << b, 2'b00);
      rd(OFS_STATUS, 32'hFF, 32'h0, 2'b00, "status");
      cmp("irq", 32'h0, {31'h0, irq});
   endtask
   task automatic acc(input logic f, input logic [15:0] ad);
      @(posedge core_clk);
      fetch_valid <= f;
      data_valid <= !f;
      fetch_addr <= ad;
      data_addr <= ad;
      @(posedge core_clk);
      fetch_valid <= 1'b0;
      data_valid <= 1'b0;
   endtask
   task automatic rs(input logic [7:0] opt);
      rst <= 1'b1;
      option_byte <= opt;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
   endtask
   task automatic test_done;
      if (err_total == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // main sequence: run with closed window first, then open window, then off
   initial
   begin
      rs(8'h10);
      rd(OFS_IMS, 32'hFF, {24'h0, IMS_RESET}, 2'b00, "ims");
      rd(OFS_IXS, 32'hFF, {24'h0, IXS_RESET}, 2'b00, "ixs");
      rd(8'h20, 32'hFFFFFFFF, 32'h0, 2'b10, "unmapped");
      wr(8'h02, 32'h0, 2'b10);
      wr(OFS_STATUS, 32'hFF, 2'b00);
      rd(OFS_STATUS, 32'hFF, 32'h0, 2'b00, "status");
      wr(OFS_INT_EN, 32'h3F, 2'b00);
      rd(OFS_INT_EN, 32'hFF, 32'h3F, 2'b00, "int_en");
      repeat (1700) @(posedge core_clk);
      rd(OFS_COUNT, 32'h000FFFFE, 32'h00080002, 2'b00, "count");
      wr(OFS_CLEAR, {24'h0, CLEAR_KEY}, 2'b00);
      req(1'b0);
      rd(OFS_COUNT, 32'h000CFFFE, 32'h000C0000, 2'b00, "count");
      wr(OFS_CLEAR, {24'h0, CLEAR_KEY}, 2'b00);
      ev(ST_WINDOW);
      wr(OFS_CLEAR, 32'h55, 2'b00);
      ev(ST_BAD_KEY);
      wr(OFS_CLEAR_BIT, {24'h0, CLEAR_KEY}, 2'b00);
      ev(ST_BIT_OP);
      wr(OFS_IMS, 32'h04, 2'b00);
      acc(1'b1, 16'h1000);
      req(1'b0);
      acc(1'b1, 16'h8000);
      ev(ST_FETCH);
      acc(1'b0, 16'hFB00);
      acc(1'b0, 16'hFFE0);
      req(1'b0);
      acc(1'b0, 16'h8000);
      ev(ST_DATA);
      wr(OFS_INT_EN, 32'h0, 2'b00);
      wr(OFS_CLEAR, 32'h00, 2'b00);
      req(1'b1);
      cmp("irq", 32'h0, {31'h0, irq});
      rs(8'h70);
      wr(OFS_CLEAR, {24'h0, CLEAR_KEY}, 2'b00);
      wr(OFS_CLEAR, {24'h0, CLEAR_KEY}, 2'b00);
      req(1'b0);
      rs(8'h00);
      wr(OFS_IMS, 32'h04, 2'b00);
      wr(OFS_CLEAR, 32'h55, 2'b00);
      acc(1'b1, 16'h8000);
      req(1'b0);
      rd(OFS_COUNT, 32'h00080000, 32'h0, 2'b00, "count");
      test_done;
   end

   // hang guard: the whole sequence needs well under 5000 cycles
   initial
   begin
      repeat (20000) @(posedge core_clk);
      err_total++;
      test_done;
   end
endmodule

bind wwdt_top wwdt_properties i_wwdt_properties (.*);
